/* dv/oag_mem_model.sv */
`timescale 1ns/1ps
// ----------------------------------------------------------------
// Instruction and workspace memory, one word per even address
// ----------------------------------------------------------------
module oag_mem_model
(
  // Clock
  input  wire logic        core_clk,
  // Requests from the generator
  input  wire logic        mem_rd,
  input  wire logic        mem_wr,
  input  wire logic [15:0] mem_addr,
  input  wire logic [15:0] mem_wdata,
  // Read answer
  output logic      [15:0] mem_rdata
);
  logic [15:0] mem [0:32767];

  // Word answers in the cycle the registered read strobe stands; outside
  // it the inverse shows, so a badly timed sample never sees the word
  assign mem_rdata = mem_rd ? mem[mem_addr[15:1]] : ~mem[mem_addr[15:1]];

  // Word storage
  always @(posedge core_clk)
  begin
    if (mem_wr)
      mem[mem_addr[15:1]] <= mem_wdata;
  end
endmodule : oag_mem_model

/* dv/oag_operand_addr_gen_tb_top.sv */
`timescale 1ns/1ps
module oag_operand_addr_gen_tb_top
  import oag_pkg::*;
;
  // ----------------------------------------------------------------
  // Signals, clock and instances
  // ----------------------------------------------------------------
  logic        core_clk;
  logic        resetn;
  logic [2:0]  reg_addr;
  logic [15:0] reg_wdata;
  logic        reg_wr;
  logic        reg_rd;
  logic [15:0] reg_rdata;
  logic        mem_rd;
  logic        mem_wr;
  logic [15:0] mem_addr;
  logic [15:0] mem_wdata;
  logic [15:0] mem_rdata;
  logic        done_pulse;
  logic [15:0] src_ea;
  logic [15:0] dst_ea;
  int          n_fail;
  int          total_checks;
  int          cyc = 0;
  logic [15:0] j_ins [3] = '{16'h1003, 16'h1302, 16'h1302};
  logic [15:0] j_st  [3] = '{16'h0000, 16'h0000, 16'h2000};
  logic [15:0] j_pc  [3] = '{16'h0708, 16'h0702, 16'h0706};

  initial
  begin
    core_clk = 1'b0;
    forever #4 core_clk = ~core_clk;
  end

  oag_operand_addr_gen u_dut (.core_clk(core_clk), .resetn(resetn), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .mem_rd(mem_rd), .mem_wr(mem_wr), .mem_addr(mem_addr), .mem_wdata(mem_wdata),
    .mem_rdata(mem_rdata), .done_pulse(done_pulse), .src_ea(src_ea), .dst_ea(dst_ea));

  oag_mem_model u_mem (.core_clk(core_clk), .mem_rd(mem_rd), .mem_wr(mem_wr),
    .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_rdata(mem_rdata));

  // ----------------------------------------------------------------
  // Access tasks and comparison
  // ----------------------------------------------------------------
  task automatic test_done();
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : test_done

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      n_fail++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // A gap cycle after each strobe keeps every strobe a clean pulse
  task automatic wr(input logic [2:0] a, input logic [15:0] d);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge core_clk);
    reg_wr <= 1'b0;
    @(posedge core_clk);
  endtask : wr

  task automatic rchk(input logic [2:0] a, input logic [15:0] exp);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1;
    chk(reg_rdata, exp);
    @(posedge core_clk);
  endtask : rchk

  task automatic put(input logic [15:0] a, input logic [15:0] d);
    u_mem.mem[a[15:1]] = d;
  endtask : put

  // Start at a program counter and wait for the finish pulse, bounded
  task automatic go(input logic [15:0] pc);
    int k;
    wr(REG_PC, pc);
    wr(REG_CTRL, 16'h0001);
    k = 0;
    while (done_pulse !== 1'b1 && k < 60)
    begin
      @(posedge core_clk);
      #1;
      k++;
    end
    chk({15'h0000, done_pulse}, 16'h0001);
    // First edge lets a write-back issued with the finish pulse land
    repeat (2) @(posedge core_clk);
  endtask : go

  // Hang guard, far beyond the roughly 130 cycles the tests need
  always @(posedge core_clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 20000)
    begin
      n_fail++;
      test_done();
    end
  end

  // ----------------------------------------------------------------
  // Test sequence
  // ----------------------------------------------------------------
  initial
  begin
    n_fail = 0;
    total_checks = 0;
    resetn = 1'b0;
    reg_addr = 3'h0;
    reg_wdata = 16'h0000;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    repeat (3) @(posedge core_clk);
    resetn <= 1'b1;
    rchk(REG_PC, PC_RST);
    rchk(REG_WP, WP_RST);
    rchk(REG_ST, ST_RST);
    // Workspace at 2000; register zero non-zero so misuse as index shows
    wr(REG_WP, 16'h2000);
    put(16'h2000, 16'h0010);
    put(16'h2002, 16'h0004);
    put(16'h2006, 16'hfd00);
    // Both operands symbolic
    put(16'h0100, 16'hc820);
    put(16'h0102, 16'hff0a);
    put(16'h0104, 16'hff08);
    go(16'h0100);
    chk(src_ea, 16'hff0a);
    chk(dst_ea, 16'hff08);
    // Symbolic source, destination indexed by register one
    put(16'h0200, 16'hc860);
    put(16'h0202, 16'hff00);
    put(16'h0204, 16'hff02);
    go(16'h0200);
    chk(src_ea, 16'hff00);
    chk(dst_ea, 16'hff06);
    // Autoincrement destination, word then byte
    for (int i = 0; i < 2; i++)
    begin
      put(16'h2008, i ? 16'hfd01 : 16'hfd00);
      put(16'h0300, i ? 16'hdd01 : 16'hcd01);
      go(16'h0300);
      chk(src_ea, 16'h2002);
      chk(dst_ea, i ? 16'hfd01 : 16'hfd00);
      chk(u_mem.mem[16'h1004], 16'hfd02);
    end
    // Indirect source through register three, pointer left untouched
    put(16'h0400, 16'hc153);
    go(16'h0400);
    chk(src_ea, 16'hfd00);
    chk(dst_ea, 16'h200a);
    chk(u_mem.mem[16'h1003], 16'hfd00);
    rchk(REG_SEA, 16'hfd00);
    rchk(REG_DEA, 16'h200a);
    // Immediate loads of workspace pointer and interrupt mask
    put(16'h0500, 16'h02e0);
    put(16'h0502, 16'h3c00);
    go(16'h0500);
    rchk(REG_WP, 16'h3c00);
    rchk(REG_IMM, 16'h3c00);
    put(16'h0600, 16'h0300);
    put(16'h0602, 16'h0005);
    go(16'h0600);
    rchk(REG_ST, 16'h0005);
    // Unconditional jump, then equal-jump with the condition clear and set
    for (int i = 0; i < 3; i++)
    begin
      wr(REG_ST, j_st[i]);
      put(16'h0700, j_ins[i]);
      go(16'h0700);
      // Byte bit of the jump word, sticky done, kind jump, dst flag left by the immediate
      rchk(REG_STAT, i == 1 ? 16'h00aa : 16'h00ea);
      rchk(REG_PC, j_pc[i]);
    end
    wr(REG_CTRL, 16'h0002);
    rchk(REG_STAT, 16'h00e8);
    test_done();
  end
endmodule : oag_operand_addr_gen_tb_top

/* rtl/oag_dec_if.sv */
`timescale 1ns/1ps
interface oag_dec_if;
  import oag_pkg::*;
  logic [15:0] instr;     // Current instruction word
  logic [15:0] wp;        // Workspace pointer
  logic        sel;       // 0 source operand, 1 destination operand
  logic [1:0]  mode;      // Mode field of the selected operand
  logic [3:0]  regn;      // Register field of the selected operand
  logic        byte_op;   // Byte indicator
  logic        indexed;   // Symbolic mode with a non-zero register field
  logic [15:0] reg_addr;  // Memory address of the selected register
  logic [15:0] step;      // Autoincrement amount

  modport dec (input instr, wp, sel, output mode, regn, byte_op, indexed, reg_addr, step);
  modport use_side (output instr, wp, sel, input mode, regn, byte_op, indexed, reg_addr, step);
endinterface : oag_dec_if

/* rtl/oag_operand_addr_gen.sv */
// Decided for this implementation: the placing of the registers and strobed register access.
`timescale 1ns/1ps
// Contract
// RULE1: Autoincrement adds one for bytes, two for words
// RULE2: Symbolic address is the full extension word
// RULE3: Symbolic mode fetches next instruction-memory word
// RULE4: Zero register field means non-indexed symbolic
// RULE5: Register zero is never an index register
// RULE6: Indexed address is extension plus index register
// RULE7: Source extension word precedes destination extension word
// RULE8: Indirect pointers come only from workspace registers
// RULE9: Only symbolic operands are ever indexed
// RULE10: Word addresses even; bytes use consecutive addresses
// RULE11: Immediate value from extension word, WP or mask
// RULE12: Jumps change PC always or on status
// RULE13: Mode 00 operand is the workspace register
// RULE14: Mode 01 uses register value as address
// RULE15: Byte bit set selects byte, clear selects word
// RULE16: Byte access to register uses left byte
// RULE17: Two-operand field layout, bit 0 most significant
// RULE18: Register n lives at WP plus 2n
module oag_operand_addr_gen
  import oag_pkg::*;
#(
  parameter int DATA_W = 16
)
(
  // Clock and reset
  input  wire logic        core_clk,
  input  wire logic        resetn,
  // Register port
  input  wire logic [2:0]  reg_addr,
  input  wire logic [15:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [15:0] reg_rdata,
  // Instruction and workspace memory
  output logic             mem_rd,
  output logic             mem_wr,
  output logic      [15:0] mem_addr,
  output logic      [15:0] mem_wdata,
  input  wire logic [15:0] mem_rdata,
  // Results
  output logic             done_pulse,
  output logic      [15:0] src_ea,
  output logic      [15:0] dst_ea
);

  // ----------------------------------------------------------------
  // Elaboration check
  // ----------------------------------------------------------------
  // Field positions and the 16-bit address sum assume a 16-bit word
  generate
    if (DATA_W != 16)
    begin : g_bad_width
      $error("oag_operand_addr_gen supports only DATA_W = 16");
    end
  endgenerate

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  oag_state_t  state;
  oag_state_t  next_state;
  logic [15:0] pc;
  logic [15:0] wp;
  logic [15:0] status_word;
  logic [15:0] instr;
  logic [15:0] ext;
  logic [15:0] imm_val;
  logic        opnd;
  logic        done_flag;
  logic [1:0]  kind;
  logic        src_is_reg;
  logic        dst_is_reg;
  logic        taken;

  // ----------------------------------------------------------------
  // Operand decoder
  // ----------------------------------------------------------------
  oag_dec_if dif ();
  assign dif.instr = instr;
  assign dif.wp    = wp;
  assign dif.sel   = opnd;

  oag_opnd_dec u_dec (
    .d (dif.dec)
  );

  // ----------------------------------------------------------------
  // Register port decode
  // ----------------------------------------------------------------
  wire logic idle      = (state == S_IDLE);
  wire logic wr_ctrl   = reg_wr && (reg_addr == REG_CTRL);
  wire logic go        = wr_ctrl && reg_wdata[CTRL_GO] && idle;
  wire logic clr_done  = wr_ctrl && reg_wdata[CTRL_CLR];
  // PC, WP and status belong to the sequencer while it runs
  wire logic wr_pc     = reg_wr && (reg_addr == REG_PC) && idle;
  wire logic wr_wp     = reg_wr && (reg_addr == REG_WP) && idle;
  wire logic wr_st     = reg_wr && (reg_addr == REG_ST) && idle;

  wire logic [15:0] stat_word = {8'h00, dif.byte_op, taken, dst_is_reg, src_is_reg,
                                 kind, done_flag, !idle};
  logic [15:0] rd_mux;

  // Read selection
  always_comb
  begin
    case (reg_addr)
      REG_STAT: rd_mux = stat_word;
      REG_PC:   rd_mux = pc;
      REG_WP:   rd_mux = wp;
      REG_ST:   rd_mux = status_word;
      REG_SEA:  rd_mux = src_ea;
      REG_DEA:  rd_mux = dst_ea;
      REG_IMM:  rd_mux = imm_val;
      default:  rd_mux = 16'h0000;
    endcase
  end

  // ----------------------------------------------------------------
  // Instruction classes
  // ----------------------------------------------------------------
  wire logic is_two   = (instr[15:14] != 2'b00);
  wire logic is_lwpi  = (instr[15:5] == LWPI_CODE);
  wire logic is_limi  = (instr[15:5] == LIMI_CODE);
  wire logic is_imm   = ((instr[15:8] == IMM_GROUP) && (instr[15:5] != STWP_CODE) &&
                         (instr[15:5] != STST_CODE)) || is_limi;
  wire logic is_jump  = (instr[15:12] == JMP_GROUP) && (instr[11:8] <= JMP_LAST);

  // ----------------------------------------------------------------
  // Jump condition and target
  // ----------------------------------------------------------------
  wire logic st_lgt = status_word[ST_LGT];
  wire logic st_agt = status_word[ST_AGT];
  wire logic st_eq  = status_word[ST_EQ];
  wire logic st_c   = status_word[ST_C];
  wire logic st_ov  = status_word[ST_OV];
  wire logic st_op  = status_word[ST_OP];
  logic      jump_ok;

  // Condition test on the status word
  always_comb
  begin
    case (instr[11:8])
      J_ALW:   jump_ok = 1'b1;
      J_LT:    jump_ok = !st_agt && !st_eq;
      J_LE:    jump_ok = !st_lgt || st_eq;
      J_EQ:    jump_ok = st_eq;
      J_HE:    jump_ok = st_lgt || st_eq;
      J_GT:    jump_ok = st_agt;
      J_NE:    jump_ok = !st_eq;
      J_NC:    jump_ok = !st_c;
      J_OC:    jump_ok = st_c;
      J_NO:    jump_ok = !st_ov;
      J_L:     jump_ok = !st_lgt && !st_eq;
      J_H:     jump_ok = st_lgt && !st_eq;
      J_OP:    jump_ok = st_op;
      default: jump_ok = 1'b0;
    endcase
  end

  // Displacement counts words from the word after the jump
  wire logic [15:0] jump_off    = {{7{instr[7]}}, instr[7:0], 1'b0};
  wire logic [15:0] jump_target = pc + jump_off;
  wire logic [15:0] pc_step     = pc + STEP_WORD;

  // ----------------------------------------------------------------
  // Effective address forming
  // ----------------------------------------------------------------
  // A word access drops bit 0 so it never lands on an odd byte
  function automatic logic [15:0] oag_align(input logic [15:0] a, input logic is_byte);
    oag_align = is_byte ? a : {a[15:1], 1'b0};
  endfunction : oag_align

  wire logic [15:0] idx_sum = ext + mem_rdata;  // [RULE6]

  logic        ea_we;
  logic        ea_reg;
  logic [15:0] next_ea;
  logic        next_rd;
  logic        next_wr;
  logic [15:0] next_addr;
  logic [15:0] next_wdata;
  logic        adv;
  logic        finish;

  // Sequencer next-state and memory requests
  always_comb
  begin
    next_state = state;
    ea_we      = 1'b0;
    ea_reg     = 1'b0;
    next_ea    = 16'h0000;
    next_rd    = 1'b0;
    next_wr    = 1'b0;
    next_addr  = 16'h0000;
    next_wdata = 16'h0000;
    adv        = 1'b0;
    finish     = 1'b0;
    case (state)
      S_IDLE:
      begin
        if (go)
        begin
          next_rd    = 1'b1;
          next_addr  = pc;
          next_state = S_FETCH;
        end
      end
      S_FETCH:
        next_state = S_DECODE;
      S_DECODE:
      begin
        if (is_two)
          next_state = S_OPND;
        else if (is_imm)
        begin
          next_rd    = 1'b1;  // Immediate lives in the extension word [RULE11]
          next_addr  = pc;
          next_state = S_IMM;
        end
        else
          finish = 1'b1;
      end
      S_OPND:
      begin
        case (dif.mode)
          MODE_DIR:
          begin
            // Register's own word; a byte access sees its left byte
            ea_we   = 1'b1;              // [RULE13] [RULE16]
            ea_reg  = 1'b1;
            next_ea = dif.reg_addr;      // [RULE9]
            adv     = 1'b1;
          end
          MODE_SYM:
          begin
            next_rd    = 1'b1;           // [RULE3] [RULE7]
            next_addr  = pc;
            next_state = S_EXT;
          end
          default:
          begin
            // Pointer comes from a workspace register, never memory
            next_rd    = 1'b1;           // [RULE8] [RULE14]
            next_addr  = dif.reg_addr;
            next_state = S_REG;
          end
        endcase
      end
      S_EXT:
      begin
        if (dif.indexed)
        begin
          next_rd    = 1'b1;             // [RULE4] [RULE5]
          next_addr  = dif.reg_addr;
          next_state = S_IDX;
        end
        else
        begin
          ea_we   = 1'b1;
          next_ea = oag_align(mem_rdata, dif.byte_op);  // [RULE2] [RULE10]
          adv     = 1'b1;
        end
      end
      S_IDX:
      begin
        ea_we   = 1'b1;
        next_ea = oag_align(idx_sum, dif.byte_op);      // [RULE6] [RULE10]
        adv     = 1'b1;
      end
      S_REG:
      begin
        ea_we   = 1'b1;
        next_ea = oag_align(mem_rdata, dif.byte_op);    // [RULE14] [RULE10]
        adv     = 1'b1;
        if (dif.mode == MODE_AUTO)
        begin
          next_wr    = 1'b1;             // [RULE1]
          next_addr  = dif.reg_addr;
          next_wdata = mem_rdata + dif.step;
        end
      end
      S_IMM:
        finish = 1'b1;
      default:
        next_state = S_IDLE;
    endcase
    if (adv && opnd)
      finish = 1'b1;
    else if (adv)
      next_state = S_OPND;
    if (finish)
      next_state = S_IDLE;
  end

  // ----------------------------------------------------------------
  // Sequencer registers
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk)
  begin
    if (!resetn)
    begin
      state     <= S_IDLE;
      mem_rd    <= 1'b0;
      mem_wr    <= 1'b0;
      mem_addr  <= 16'h0000;
      mem_wdata <= 16'h0000;
      instr     <= 16'h0000;
      ext       <= 16'h0000;
      opnd      <= 1'b0;
    end
    else
    begin
      state     <= next_state;
      mem_rd    <= next_rd;
      mem_wr    <= next_wr;
      mem_addr  <= next_addr;
      mem_wdata <= next_wdata;
      if (state == S_FETCH)
        instr <= mem_rdata;
      if (state == S_EXT)
        ext <= mem_rdata;
      if (state == S_DECODE)
        opnd <= 1'b0;
      else if (adv)
        opnd <= 1'b1;              // Source first, then destination [RULE7]
    end
  end

  // Program counter: steps past each word read from the stream
  always_ff @(posedge core_clk)
  begin
    if (!resetn)
      pc <= PC_RST;
    else if (wr_pc)
      pc <= reg_wdata;
    else if (state == S_FETCH || state == S_EXT || state == S_IMM)
      pc <= pc_step;               // [RULE7]
    else if (state == S_DECODE && is_jump && jump_ok)
      pc <= jump_target;           // [RULE12]
  end

  // Workspace pointer and status word
  always_ff @(posedge core_clk)
  begin
    if (!resetn)
    begin
      wp          <= WP_RST;
      status_word <= ST_RST;
    end
    else
    begin
      if (wr_wp)
        wp <= reg_wdata;
      else if (state == S_IMM && is_lwpi)
        wp <= mem_rdata;           // [RULE11]
      if (wr_st)
        status_word <= reg_wdata;
      else if (state == S_IMM && is_limi)
        status_word[3:0] <= mem_rdata[3:0];  // Interrupt mask [RULE11]
    end
  end

  // Effective addresses and result flags
  always_ff @(posedge core_clk)
  begin
    if (!resetn)
    begin
      src_ea     <= 16'h0000;
      dst_ea     <= 16'h0000;
      src_is_reg <= 1'b0;
      dst_is_reg <= 1'b0;
      imm_val    <= 16'h0000;
      kind       <= KIND_OTHER;
      taken      <= 1'b0;
    end
    else
    begin
      if (ea_we && !opnd)
      begin
        src_ea     <= next_ea;
        src_is_reg <= ea_reg;
      end
      if (ea_we && opnd)
      begin
        dst_ea     <= next_ea;
        dst_is_reg <= ea_reg;
      end
      if (state == S_IMM)
      begin
        imm_val    <= mem_rdata;   // [RULE11]
        dst_ea     <= wp + {11'h000, instr[3:0], 1'b0};
        dst_is_reg <= 1'b1;
      end
      if (state == S_DECODE)
      begin
        kind  <= is_two ? KIND_TWO : is_imm ? KIND_IMM : is_jump ? KIND_JUMP : KIND_OTHER;
        taken <= is_jump && jump_ok;
      end
    end
  end

  // Done flag: completion wins over a clear in the same cycle
  always_ff @(posedge core_clk)
  begin
    if (!resetn)
    begin
      done_flag  <= 1'b0;
      done_pulse <= 1'b0;
      reg_rdata  <= 16'h0000;
    end
    else
    begin
      done_flag  <= finish || (done_flag && !clr_done);
      done_pulse <= finish;
      reg_rdata  <= reg_rd ? rd_mux : 16'h0000;  // Valid only the cycle after
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!resetn);

  AST_AUTO_STEP: assert property ( // [RULE1]
    (state == S_REG && dif.mode == MODE_AUTO) |=>
      mem_wr && mem_wdata == $past(mem_rdata) + (instr[12] ? STEP_BYTE : STEP_WORD))
    else $error("autoincrement write-back wrong");

  AST_SYM_FETCH: assert property ( // [RULE3]
    (state == S_OPND && dif.mode == MODE_SYM) |=> mem_rd && mem_addr == $past(pc) && state == S_EXT)
    else $error("symbolic operand did not fetch next word");

  AST_NO_R0_INDEX: assert property ( // [RULE5]
    (state == S_EXT && dif.regn == 4'h0) |=> !mem_rd && state != S_IDX)
    else $error("register zero used as index");

  AST_INDEX_SUM: assert property ( // [RULE6]
    (state == S_IDX && opnd) |=>
      dst_ea == (($past(ext) + $past(mem_rdata)) & (instr[12] ? 16'hffff : 16'hfffe)))
    else $error("indexed destination address wrong");

  AST_EXT_ORDER: assert property ( // [RULE7]
    (state == S_EXT) |=> pc == $past(pc) + STEP_WORD)
    else $error("extension word did not advance program counter");

  AST_IND_PTR: assert property ( // [RULE8]
    (state == S_OPND && dif.mode[0]) |=> mem_rd && mem_addr == $past(wp) + {11'h000, $past(dif.regn), 1'b0})
    else $error("indirect pointer not read from workspace register");

  AST_WORD_EVEN: assert property ( // [RULE10]
    (ea_we && !dif.byte_op) |-> !next_ea[0])
    else $error("odd word address formed");

  AST_DIRECT_REG: assert property ( // [RULE13]
    (state == S_OPND && dif.mode == MODE_DIR && opnd) |=> dst_is_reg && dst_ea == $past(dif.reg_addr))
    else $error("direct register address wrong");

  AST_JUMP_HOLD: assert property ( // [RULE12]
    (state == S_DECODE && is_jump && !jump_ok) |=> pc == $past(pc) && !taken)
    else $error("untaken jump changed program counter");

  AST_LOAD_WP: assert property ( // [RULE11]
    (state == S_IMM && is_lwpi) |=> wp == $past(mem_rdata) && done_pulse)
    else $error("workspace pointer not loaded from immediate");

endmodule : oag_operand_addr_gen

/* rtl/oag_opnd_dec.sv */
`timescale 1ns/1ps
module oag_opnd_dec
  import oag_pkg::*;
(
  // Decode view
  oag_dec_if.dec d
);

  // ----------------------------------------------------------------
  // Field split
  // ----------------------------------------------------------------
  // Two-operand layout: destination mode/register sit above source ones
  wire logic [1:0] dst_mode_field = d.instr[11:10];  // [RULE17]
  wire logic [3:0] dst_reg_field  = d.instr[9:6];
  wire logic [1:0] src_mode_field = d.instr[5:4];
  wire logic [3:0] src_reg_field  = d.instr[3:0];

  assign d.mode    = d.sel ? dst_mode_field : src_mode_field;
  assign d.regn    = d.sel ? dst_reg_field : src_reg_field;
  assign d.byte_op = d.instr[12];  // Set means byte operand [RULE15]

  // ----------------------------------------------------------------
  // Derived values
  // ----------------------------------------------------------------
  // Register zero never indexes: a zero field means plain symbolic
  assign d.indexed  = (d.mode == MODE_SYM) && (d.regn != 4'h0);  // [RULE4] [RULE5]
  assign d.reg_addr = d.wp + {11'h000, d.regn, 1'b0};          // [RULE18]
  assign d.step     = d.byte_op ? STEP_BYTE : STEP_WORD;       // [RULE1]

endmodule : oag_opnd_dec

/* rtl/oag_pkg.sv */
package oag_pkg;

  // ----------------------------------------------------------------
  // Register port map
  // ----------------------------------------------------------------
  localparam logic [2:0] REG_CTRL = 3'h0;  // Write: go, clear done
  localparam logic [2:0] REG_STAT = 3'h1;  // Read: busy, done, kind, flags
  localparam logic [2:0] REG_PC   = 3'h2;  // Program counter
  localparam logic [2:0] REG_WP   = 3'h3;  // Workspace pointer
  localparam logic [2:0] REG_ST   = 3'h4;  // Status word
  localparam logic [2:0] REG_SEA  = 3'h5;  // Source effective address
  localparam logic [2:0] REG_DEA  = 3'h6;  // Destination effective address
  localparam logic [2:0] REG_IMM  = 3'h7;  // Immediate operand value

  // Control and status field positions
  localparam int CTRL_GO      = 0;
  localparam int CTRL_CLR     = 1;
  localparam int STAT_BUSY    = 0;
  localparam int STAT_DONE    = 1;
  localparam int STAT_KIND_LO = 2;
  localparam int STAT_SRC_REG = 4;
  localparam int STAT_DST_REG = 5;
  localparam int STAT_TAKEN   = 6;
  localparam int STAT_BYTE    = 7;

  // Reset values
  localparam logic [15:0] PC_RST = 16'h0000;
  localparam logic [15:0] WP_RST = 16'h0000;
  localparam logic [15:0] ST_RST = 16'h0000;

  // ----------------------------------------------------------------
  // Addressing modes and instruction classes
  // ----------------------------------------------------------------
  localparam logic [1:0] MODE_DIR  = 2'b00;  // Workspace register
  localparam logic [1:0] MODE_IND  = 2'b01;  // Register indirect
  localparam logic [1:0] MODE_SYM  = 2'b10;  // Symbolic, maybe indexed
  localparam logic [1:0] MODE_AUTO = 2'b11;  // Indirect, autoincrement

  localparam logic [1:0] KIND_TWO   = 2'h0;
  localparam logic [1:0] KIND_IMM   = 2'h1;
  localparam logic [1:0] KIND_JUMP  = 2'h2;
  localparam logic [1:0] KIND_OTHER = 2'h3;

  localparam logic [7:0]  IMM_GROUP = 8'h02;    // Upper byte of immediate group
  localparam logic [10:0] LWPI_CODE = 11'h017;  // Bits 15:5 of load-WP-immediate
  localparam logic [10:0] LIMI_CODE = 11'h018;  // Bits 15:5 of load-mask-immediate
  localparam logic [10:0] STWP_CODE = 11'h015;  // Bits 15:5 of store-WP, no extension word
  localparam logic [10:0] STST_CODE = 11'h016;  // Bits 15:5 of store-status, no extension word
  localparam logic [3:0]  JMP_GROUP = 4'h1;     // Upper nibble of jump group
  localparam logic [3:0]  JMP_LAST  = 4'hc;     // Highest jump sub-code

  // Jump sub-codes
  localparam logic [3:0] J_ALW = 4'h0;
  localparam logic [3:0] J_LT  = 4'h1;
  localparam logic [3:0] J_LE  = 4'h2;
  localparam logic [3:0] J_EQ  = 4'h3;
  localparam logic [3:0] J_HE  = 4'h4;
  localparam logic [3:0] J_GT  = 4'h5;
  localparam logic [3:0] J_NE  = 4'h6;
  localparam logic [3:0] J_NC  = 4'h7;
  localparam logic [3:0] J_OC  = 4'h8;
  localparam logic [3:0] J_NO  = 4'h9;
  localparam logic [3:0] J_L   = 4'ha;
  localparam logic [3:0] J_H   = 4'hb;
  localparam logic [3:0] J_OP  = 4'hc;

  // Status word bits, bit 0 being the most significant
  localparam int ST_LGT = 15;
  localparam int ST_AGT = 14;
  localparam int ST_EQ  = 13;
  localparam int ST_C   = 12;
  localparam int ST_OV  = 11;
  localparam int ST_OP  = 10;

  localparam logic [15:0] STEP_BYTE = 16'h0001;
  localparam logic [15:0] STEP_WORD = 16'h0002;

  // Sequencer states
  typedef enum logic [7:0] {
    S_IDLE   = 8'h01,
    S_FETCH  = 8'h02,
    S_DECODE = 8'h04,
    S_OPND   = 8'h08,
    S_EXT    = 8'h10,
    S_IDX    = 8'h20,
    S_REG    = 8'h40,
    S_IMM    = 8'h80
  } oag_state_t;

endpackage : oag_pkg
